// ### haptic_cfg.svh
// Constants for the input interpretation control block
`ifndef HAPTIC_CFG_SVH
`define HAPTIC_CFG_SVH
`define FBC2_OFFSET      8'h1C
`define FBC2_RESET       8'hF5
`define BIT_INTERP       7
`define BIT_STAB         6
`define SAMP_HI          5
`define SAMP_LO          4
`define HOLD_HI          3
`define HOLD_LO          2
`define DECAY_HI         1
`define DECAY_LO         0
`define SAMPLE_US0       150
`define SAMPLE_US1       200
`define SAMPLE_US2       250
`define SAMPLE_US3       300
`define HOLD_UNIT_CYC    16'h0010
`define DECAY_UNIT_CYC   16'h0020
`define CLK_MHZ          125
`define STAB_SHIFT       2
`endif

// ### haptic_pkg.sv
// Types shared by the input interpretation control block
package haptic_pkg;
  typedef struct packed {
    logic       input_interpretation_select;
    logic       braking_gain_reducer;
    logic [1:0] resonance_sample_sel;
    logic [1:0] conversion_holdoff;
    logic [1:0] current_decay_interval;
  } fbc2_t;
  typedef struct packed {
    logic       wr;   // Write strobe
    logic [7:0] addr; // Register offset
    logic [7:0] wdata; // Write data
  } reg_req_t;
endpackage

// ### drive_map.sv
// Combinational mapping of input level to signed drive and brake
`timescale 1ns/10ps
`default_nettype none
module drive_map #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] level,     // Input level, 0 to full scale
  input  wire logic         bidir,     // Bidirectional interpretation
  input  wire logic         closed,    // Closed-loop operation
  input  wire logic         fb_brake,  // Brake request from feedback
  output logic signed [W:0] drive,     // Signed drive request
  output logic              brake      // Braking applied
);
  localparam logic [W:0] HALF = (W+1)'(1) << (W-1);
  wire logic [W:0] lvl_x    = {1'b0, level};
  wire logic [W:0] centred  = lvl_x - HALF;
  wire logic       above    = lvl_x > HALF;
  wire logic       below    = lvl_x < HALF;
  wire logic [W:0] dbl      = {centred[W-1:0], 1'b0};
  // Unidirectional: level unchanged; bidirectional open loop: signed about half scale; closed loop: only upper half
  assign drive = !bidir ? $signed(lvl_x) :
                 !closed ? $signed(dbl) :
                 above ? $signed(dbl) : '0;
  // Brake source per mode
  assign brake = (bidir && !closed) ? below : fb_brake;
endmodule // drive_map
`default_nettype wire

// ### haptic_input_interpret_ctrl.sv
// Second feedback-control register and input interpretation engine
// How it works
// - Interpretation selector resets to 1, bidirectional signed input about half scale
// - Bidirectional open loop brakes only below half-scale input
// - Bidirectional open loop output is linear: 0% full brake to 100% full drive
// - Bidirectional closed loop: none up to half, then linear to full
// - Bidirectional closed loop braking comes from feedback, not input
// - Braking_gain_reducer set lowers loop gain as braking nears its end
// - Sample field codes 0..3 select 150, 200, 250, 300 us; reset 3
// - Holdoff field, reset 1, delays each back-EMF conversion start
// - Decay field, reset 1, sets current dissipation gap between PWM cycles
// - Selector 0: unidirectional, 0% none, 50% half, feedback braking
`timescale 1ns/10ps
`default_nettype none
`include "haptic_cfg.svh"
module haptic_input_interpret_ctrl #(
  parameter int W  = 8,
  parameter int GW = 8
) (
  input  wire logic                 sys_clk,      // 125 MHz clock
  input  wire logic                 rst_b,        // Sync reset, active low
  input  wire logic                 clk_en,       // Freezes state when low
  input  wire haptic_pkg::reg_req_t req,          // Register write port
  output logic [7:0]                rdata_r,      // Register read data
  input  wire logic [W-1:0]         level,        // Input level
  input  wire logic                 closed_loop,  // Closed-loop operation
  input  wire logic                 fb_brake,     // Feedback brake request
  input  wire logic                 brake_near_end, // Braking almost done
  input  wire logic [GW-1:0]        loop_gain,    // Nominal loop gain
  input  wire logic                 pwm_cycle_end, // PWM cycle finished
  input  wire logic                 conv_req,     // Back-EMF conversion wanted
  output logic signed [W:0]         drive_r,      // Signed drive request
  output logic                      brake_r,      // Braking active
  output logic [GW-1:0]             gain_r,       // Effective loop gain
  output logic [15:0]               sample_cyc_r, // Resonance sample cycles
  output logic                      conv_start_r, // Conversion start pulse
  output logic                      decay_r       // Decay interval active
);
  localparam int US0 = `SAMPLE_US0 * `CLK_MHZ;
  localparam int US1 = `SAMPLE_US1 * `CLK_MHZ;
  localparam int US2 = `SAMPLE_US2 * `CLK_MHZ;
  localparam int US3 = `SAMPLE_US3 * `CLK_MHZ;

  typedef enum logic [1:0] {IDLE, HOLD, DECAY} ph_t;
  ph_t ph_r;
  haptic_pkg::fbc2_t fbc_r;
  logic [15:0] cnt_r;

  // Sample code to cycle count
  function automatic logic [15:0] samp_cyc(input logic [1:0] c);
    unique case (c)
      2'h0: samp_cyc = 16'(US0);
      2'h1: samp_cyc = 16'(US1);
      2'h2: samp_cyc = 16'(US2);
      2'h3: samp_cyc = 16'(US3);
    endcase
  endfunction

  // Field code to interval length, never zero
  function automatic logic [15:0] ivl(input logic [1:0] c, input logic [15:0] u);
    ivl = 16'(({14'h0, c} + 16'h0001) * u);
  endfunction

  wire logic       wr_hit   = req.wr && req.addr == `FBC2_OFFSET;
  wire logic [15:0] hold_len  = ivl(fbc_r.conversion_holdoff, `HOLD_UNIT_CYC);
  wire logic [15:0] decay_len = ivl(fbc_r.current_decay_interval, `DECAY_UNIT_CYC);
  wire logic       cnt_done = cnt_r == 16'h0001;
  wire logic signed [W:0] drv_w;
  wire logic       brk_w;
  wire logic       stab_on  = fbc_r.braking_gain_reducer && brk_w && brake_near_end;
  wire logic [GW-1:0] gain_w = stab_on ? (loop_gain >> `STAB_SHIFT) : loop_gain;

  drive_map #(.W(W)) u_map (
    .level    (level),
    .bidir    (fbc_r.input_interpretation_select),
    .closed   (closed_loop),
    .fb_brake (fb_brake),
    .drive    (drv_w),
    .brake    (brk_w)
  );

  // Register storage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fbc_r <= `FBC2_RESET;
    end else if (clk_en && wr_hit) begin
      fbc_r <= req.wdata;
    end
  end

  // Read data and drive outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_r      <= 8'h00;
      drive_r      <= '0;
      brake_r      <= 1'b0;
      gain_r       <= '0;
      sample_cyc_r <= 16'h0000;
    end else if (clk_en) begin
      rdata_r      <= (req.addr == `FBC2_OFFSET) ? fbc_r : 8'h00;
      drive_r      <= drv_w;
      brake_r      <= brk_w;
      gain_r       <= gain_w;
      sample_cyc_r <= samp_cyc(fbc_r.resonance_sample_sel);
    end
  end

  // Holdoff before conversion, decay gap after PWM cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ph_r         <= IDLE;
      cnt_r        <= 16'h0000;
      conv_start_r <= 1'b0;
      decay_r      <= 1'b0;
    end else if (clk_en) begin
      conv_start_r <= 1'b0;
      unique case (ph_r)
        IDLE: begin
          if (pwm_cycle_end) begin
            ph_r    <= DECAY;
            cnt_r   <= decay_len;
            decay_r <= 1'b1;
          end else if (conv_req) begin
            ph_r  <= HOLD;
            cnt_r <= hold_len;
          end
        end
        HOLD: begin
          cnt_r <= cnt_r - 16'h0001;
          if (cnt_done) begin
            ph_r         <= IDLE;
            conv_start_r <= 1'b1;
          end
        end
        DECAY: begin
          cnt_r <= cnt_r - 16'h0001;
          if (cnt_done) begin
            ph_r    <= IDLE;
            decay_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Open-loop braking only below half scale
  property p_ol_brake;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && fbc_r.input_interpretation_select && !closed_loop
       && level >= W'(1 << (W-1))) |=> !brake_r;
  endproperty
  a_ol_brake: assert property (p_ol_brake) else $error("open-loop brake at high input");

  // Closed loop lower half gives no drive
  property p_cl_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && fbc_r.input_interpretation_select && closed_loop
       && level <= W'(1 << (W-1))) |=> drive_r == '0;
  endproperty
  a_cl_zero: assert property (p_cl_zero) else $error("closed-loop drive in lower half");

  // Closed loop brake follows feedback
  property p_cl_fb;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && closed_loop) |=> brake_r == $past(fb_brake);
  endproperty
  a_cl_fb: assert property (p_cl_fb) else $error("closed-loop brake not from feedback");

  // Open loop zero input gives full negative drive
  property p_ol_full;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && fbc_r.input_interpretation_select && !closed_loop && level == '0)
      |=> drive_r == -$signed((W+1)'(1) << W);
  endproperty
  a_ol_full: assert property (p_ol_full) else $error("open-loop zero not full brake");

  // Unidirectional drive equals input
  property p_uni;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && !fbc_r.input_interpretation_select) |=> drive_r == $signed({1'b0, $past(level)});
  endproperty
  a_uni: assert property (p_uni) else $error("unidirectional mapping wrong");

  // Stabilizer lowers gain near brake end
  property p_stab;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && stab_on) |=> gain_r == ($past(loop_gain) >> `STAB_SHIFT);
  endproperty
  a_stab: assert property (p_stab) else $error("gain not reduced");

  // Sample count matches code 3
  property p_samp;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && fbc_r.resonance_sample_sel == 2'h3) |=> sample_cyc_r == 16'(US3);
  endproperty
  a_samp: assert property (p_samp) else $error("sample interval wrong");

  // Holdoff of code 0 delays start by one unit
  sequence s_hold0;
    ph_r == IDLE && clk_en && !pwm_cycle_end && conv_req && fbc_r.conversion_holdoff == 2'h0;
  endsequence
  // Eight enabled cycles, two of them span one holdoff unit
  sequence s_en8;
    clk_en [*8];
  endsequence
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      s_hold0 ##1 s_en8 ##1 s_en8 |=> conv_start_r;
  endproperty
  a_hold: assert property (p_hold) else $error("conversion holdoff wrong");

  // Write is stored in the register
  property p_rw;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && wr_hit) |=> fbc_r == $past(req.wdata);
  endproperty
  a_rw: assert property (p_rw) else $error("register write lost");

  // Decay asserted after PWM end
  property p_decay;
    @(posedge sys_clk) disable iff (!rst_b)
      (clk_en && ph_r == IDLE && pwm_cycle_end) |=> decay_r;
  endproperty
  a_decay: assert property (p_decay) else $error("decay not started");
endmodule // haptic_input_interpret_ctrl
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the input interpretation control block
`timescale 1ns/10ps
`default_nettype none
`include "haptic_cfg.svh"
module tb_top;
  logic                 sys_clk;
  logic                 rst_b;
  logic                 clk_en;
  haptic_pkg::reg_req_t req;
  logic [7:0]           rdata_r;
  logic [7:0]           level;
  logic                 closed_loop;
  logic                 fb_brake;
  logic                 brake_near_end;
  logic [7:0]           loop_gain;
  logic                 pwm_cycle_end;
  logic                 conv_req;
  logic signed [8:0]    drive_r;
  logic                 brake_r;
  logic [7:0]           gain_r;
  logic [15:0]          sample_cyc_r;
  logic                 conv_start_r;
  logic                 decay_r;
  int                   error_cnt;
  int                   checked;
  int                   n;

  haptic_input_interpret_ctrl #(.W(8), .GW(8)) u_haptic_input_interpret_ctrl (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .rdata_r(rdata_r),
    .level(level), .closed_loop(closed_loop), .fb_brake(fb_brake),
    .brake_near_end(brake_near_end), .loop_gain(loop_gain), .pwm_cycle_end(pwm_cycle_end),
    .conv_req(conv_req), .drive_r(drive_r), .brake_r(brake_r), .gain_r(gain_r),
    .sample_cyc_r(sample_cyc_r), .conv_start_r(conv_start_r), .decay_r(decay_r));

  // Clock generation, 8 ns period
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare tasks, one per kind of result
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_drv(input logic [8:0] exp_d, input logic exp_b);
    checked++;
    if (drive_r !== exp_d || brake_r !== exp_b) begin
      error_cnt++;
      $display("BAD %0t drive %h/%b expected %h/%b", $time, drive_r, brake_r, exp_d, exp_b);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD %0t cycle count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Register access, entered and left at a falling edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    req.wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    @(negedge sys_clk);
    chk_val({8'h00, rdata_r}, {8'h00, exp});
  endtask
  task automatic map_chk(input logic [7:0] lv, input logic cl, input logic fb,
                         input logic [8:0] ed, input logic eb);
    level = lv;
    closed_loop = cl;
    fb_brake = fb;
    repeat (2) @(negedge sys_clk);
    chk_drv(ed, eb);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end

  // Main sequence
  initial begin
    error_cnt = 0; checked = 0; rst_b = 1'b0; clk_en = 1'b1;
    req = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
    level = 8'h00; closed_loop = 1'b0; fb_brake = 1'b0; brake_near_end = 1'b0;
    loop_gain = 8'h80; pwm_cycle_end = 1'b0; conv_req = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    reg_rd(`FBC2_OFFSET, 8'hF5);
    chk_val(sample_cyc_r, 16'h927C);
    // Unmapped and frozen writes leave the register alone
    reg_wr(8'h1D, 8'h00);
    reg_rd(`FBC2_OFFSET, 8'hF5);
    reg_rd(8'h1D, 8'h00);
    clk_en = 1'b0;
    reg_wr(`FBC2_OFFSET, 8'h00);
    clk_en = 1'b1;
    reg_rd(`FBC2_OFFSET, 8'hF5);
    // Sampling interval codes
    reg_wr(`FBC2_OFFSET, 8'hC5);
    reg_rd(`FBC2_OFFSET, 8'hC5);
    chk_val(sample_cyc_r, 16'h493E);
    reg_wr(`FBC2_OFFSET, 8'hD5);
    chk_val(sample_cyc_r, 16'h61A8);
    reg_wr(`FBC2_OFFSET, 8'hE5);
    chk_val(sample_cyc_r, 16'h7A12);
    // Bidirectional open loop, feedback brake high except at level 7F
    reg_wr(`FBC2_OFFSET, 8'hF5);
    map_chk(8'h00, 1'b0, 1'b1, 9'h100, 1'b1);
    map_chk(8'h40, 1'b0, 1'b1, 9'h180, 1'b1);
    map_chk(8'h7F, 1'b0, 1'b0, 9'h1FE, 1'b1);
    map_chk(8'h80, 1'b0, 1'b1, 9'h000, 1'b0);
    map_chk(8'hC0, 1'b0, 1'b1, 9'h080, 1'b0);
    map_chk(8'hFF, 1'b0, 1'b1, 9'h0FE, 1'b0);
    // Bidirectional closed loop
    map_chk(8'h00, 1'b1, 1'b1, 9'h000, 1'b1);
    map_chk(8'h80, 1'b1, 1'b0, 9'h000, 1'b0);
    map_chk(8'h81, 1'b1, 1'b1, 9'h002, 1'b1);
    map_chk(8'hC0, 1'b1, 1'b0, 9'h080, 1'b0);
    map_chk(8'hFF, 1'b1, 1'b1, 9'h0FE, 1'b1);
    // Braking gain reduction near the end of braking
    brake_near_end = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_val({8'h00, gain_r}, 16'h0020);
    brake_near_end = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_val({8'h00, gain_r}, 16'h0080);
    brake_near_end = 1'b1;
    reg_wr(`FBC2_OFFSET, 8'hB5);
    chk_val({8'h00, gain_r}, 16'h0080);
    brake_near_end = 1'b0;
    // Unidirectional interpretation
    reg_wr(`FBC2_OFFSET, 8'h75);
    map_chk(8'h00, 1'b1, 1'b0, 9'h000, 1'b0);
    map_chk(8'h80, 1'b1, 1'b1, 9'h080, 1'b1);
    map_chk(8'hFF, 1'b1, 1'b0, 9'h0FF, 1'b0);
    // Holdoff and decay intervals for every code
    for (int c = 0; c < 4; c++) begin
      reg_wr(`FBC2_OFFSET, {4'hF, c[1:0], c[1:0]});
      conv_req = 1'b1;
      @(negedge sys_clk);
      conv_req = 1'b0;
      n = 0;
      for (int k = 1; k < 100; k++) begin
        @(negedge sys_clk);
        if (conv_start_r === 1'b1 && n == 0) n = k;
      end
      chk_cnt(n, (c + 1) * 16);
      pwm_cycle_end = 1'b1;
      @(negedge sys_clk);
      pwm_cycle_end = 1'b0;
      n = (decay_r === 1'b1) ? 1 : 0;
      for (int k = 0; k < 160; k++) begin
        @(negedge sys_clk);
        if (decay_r === 1'b1) n++;
      end
      chk_cnt(n, (c + 1) * 32);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
